/* asrp_pkg.sv */
// package: constants and carrier types for the adc serial register port
package asrp_pkg;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_COMMAND = 6'h00;
    localparam logic [5:0] ADDR_ADC_MODE = 6'h01;
    localparam logic [5:0] ADDR_IF_MODE = 6'h02;
    localparam logic [5:0] ADDR_DATA = 6'h04;
    localparam logic [5:0] ADDR_IDENT = 6'h07;
    localparam logic [5:0] ADDR_CHAN0 = 6'h10;
    localparam logic [5:0] ADDR_SETUP0 = 6'h20;
    localparam logic [5:0] ADDR_FILT0 = 6'h28;
    localparam logic [5:0] ADDR_OFFSET0 = 6'h30;
    localparam logic [5:0] ADDR_GAIN0 = 6'h38;

    // ------------------------------------------------------------
    // command byte fields
    // ------------------------------------------------------------
    localparam int CMD_WEN_N_BIT = 7;
    localparam int CMD_READ_BIT = 6;
    localparam int CMD_ADDR_MSB = 5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_ADC_MODE = 16'h2000;
    localparam logic [15:0] RST_IF_MODE = 16'h0000;
    localparam logic [15:0] RST_CHAN0 = 16'h8001;
    localparam logic [15:0] RST_CHANX = 16'h0001;
    localparam logic [15:0] RST_SETUP0 = 16'h1000;
    localparam logic [15:0] RST_FILT0 = 16'h0500;
    localparam logic [23:0] RST_OFFSET0 = 24'h800000;
    localparam logic [23:0] RST_GAIN0 = 24'h500000;
    localparam logic [23:0] RST_DATA = 24'h000000;

    // ------------------------------------------------------------
    // interface mode field positions
    // ------------------------------------------------------------
    localparam int IFM_CONT_READ = 7;
    localparam int IFM_DATA_STAT = 6;
    localparam int IFM_REG_CHECK = 5;
    localparam int IFM_CRC_EN = 2;
    localparam int IFM_SHORT_WORD = 0;

    // ------------------------------------------------------------
    // link timing
    // ------------------------------------------------------------
    localparam int RESET_ONES = 64;
    localparam int ONES_W = 7;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_CMD = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ = 3'b100
    } asrp_state_t;

    // pin levels after synchronous sampling
    typedef struct packed {
        logic sclk;
        logic csN;
        logic din;
    } asrp_pins_t;

    // captured register write
    typedef struct packed {
        logic valid;
        logic [5:0] addr;
        logic [23:0] data;
    } asrp_wr_t;

endpackage

/* asrp_regfile.sv */
// register file: configuration state, widths and read data
`timescale 1ns/1ns
`default_nettype none
module asrp_regfile
    import asrp_pkg::*;
#(
    parameter logic [15:0] IDENT_VALUE = 16'h5a50 // arbitrary identity value
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic softRst,
    // write port
    input wire asrp_wr_t wr,
    // lookup port
    input wire logic [5:0] lookAddr,
    output logic [5:0] lookBits,
    output logic [31:0] lookData,
    output logic [15:0] ifMode
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] adcMode_q; // conversion mode, clock source
    logic [15:0] ifMode_q; // interface mode
    logic [15:0] chan_q [16]; // channel registers
    logic [15:0] setup_q [8]; // setup configuration
    logic [15:0] filt_q [8]; // filter configuration
    logic [23:0] offs_q [8]; // offset coefficients
    logic [23:0] gain_q [8]; // gain coefficients

    assign ifMode = ifMode_q;

    // mode registers, reset also by the all-ones sequence
    always_ff @(posedge clk_sys) begin
        if (rst || (clkEn && softRst)) begin
            adcMode_q <= RST_ADC_MODE;
            ifMode_q <= RST_IF_MODE;
        end else if (clkEn && wr.valid) begin
            if (wr.addr == ADDR_ADC_MODE) begin
                adcMode_q <= wr.data[15:0];
            end
            if (wr.addr == ADDR_IF_MODE) begin
                ifMode_q <= wr.data[15:0];
            end
        end
    end

    // per-entry configuration banks
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_chan
            always_ff @(posedge clk_sys) begin
                if (rst || (clkEn && softRst)) begin
                    chan_q[gi] <= (gi == 0) ? RST_CHAN0 : RST_CHANX;
                end else if (clkEn && wr.valid && wr.addr == ADDR_CHAN0 + 6'(gi)) begin
                    chan_q[gi] <= wr.data[15:0];
                end
            end
        end
        for (gi = 0; gi < 8; gi++) begin : g_setup
            always_ff @(posedge clk_sys) begin
                if (rst || (clkEn && softRst)) begin
                    setup_q[gi] <= RST_SETUP0;
                    filt_q[gi] <= RST_FILT0;
                    offs_q[gi] <= RST_OFFSET0;
                    gain_q[gi] <= RST_GAIN0;
                end else if (clkEn && wr.valid) begin
                    if (wr.addr == ADDR_SETUP0 + 6'(gi)) begin
                        setup_q[gi] <= wr.data[15:0];
                    end
                    if (wr.addr == ADDR_FILT0 + 6'(gi)) begin
                        filt_q[gi] <= wr.data[15:0];
                    end
                    if (wr.addr == ADDR_OFFSET0 + 6'(gi)) begin
                        offs_q[gi] <= wr.data;
                    end
                    if (wr.addr == ADDR_GAIN0 + 6'(gi)) begin
                        gain_q[gi] <= wr.data;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // width and read data lookup
    // ------------------------------------------------------------
    // data register grows by 8 bits when status is appended
    always_comb begin
        lookBits = 6'd16;
        lookData = 32'h0;
        if (lookAddr == ADDR_ADC_MODE) begin
            lookData = {16'h0, adcMode_q};
        end else if (lookAddr == ADDR_IF_MODE) begin
            lookData = {16'h0, ifMode_q};
        end else if (lookAddr == ADDR_DATA) begin
            lookBits = ifMode_q[IFM_DATA_STAT] ? 6'd32 : 6'd24;
            // right-aligned like every other register; the status byte trails the data
            lookData = ifMode_q[IFM_DATA_STAT] ? {RST_DATA, 8'h0} : {8'h0, RST_DATA};
        end else if (lookAddr == ADDR_IDENT) begin
            lookData = {16'h0, IDENT_VALUE};
        end else if (lookAddr >= ADDR_CHAN0 && lookAddr < ADDR_SETUP0) begin
            lookData = {16'h0, chan_q[lookAddr[3:0]]};
        end else if (lookAddr >= ADDR_SETUP0 && lookAddr < ADDR_FILT0) begin
            lookData = {16'h0, setup_q[lookAddr[2:0]]};
        end else if (lookAddr >= ADDR_FILT0 && lookAddr < ADDR_OFFSET0) begin
            lookData = {16'h0, filt_q[lookAddr[2:0]]};
        end else if (lookAddr >= ADDR_OFFSET0 && lookAddr < ADDR_GAIN0) begin
            lookBits = 6'd24;
            lookData = {8'h0, offs_q[lookAddr[2:0]]};
        end else if (lookAddr >= ADDR_GAIN0) begin
            lookBits = 6'd24;
            lookData = {8'h0, gain_q[lookAddr[2:0]]};
        end else begin
            lookBits = 6'd8; // unmapped: one byte of zeros
        end
    end

endmodule
`default_nettype wire

/* asrp_port.sv */
// serial port top: command framing, shifter and soft reset
`timescale 1ns/1ns
`default_nettype none
// How it works
// - shift on falling edge, sample rising edge
// - chip select may stay low always
// - command byte is write only
// - every exchange starts with a command
// - command: write enable, read flag, address
// - return to command after data phase
// - write data is 8/16/24 bits
// - read data is 8 to 32 bits
// - identification register at seven, read only
// - 64 ones on data in resets all
// - chip select high aborts transfer
// - reset enables channel zero only
// - setup zero buffers off, external reference
// - reset filter combined sinc, fastest rate
// - reset continuous, internal oscillator, no reference
// - reset crc and status append off
// - interface mode fields cleared at reset
module asrp_port
    import asrp_pkg::*;
#(
    parameter logic [15:0] IDENT_VALUE = 16'h5a50 // arbitrary identity value
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    // serial pins, already synchronous
    input wire logic sclk,
    input wire logic csN,
    input wire logic din,
    // serial output pin
    output logic dout,
    output logic doutOeN,
    // status
    output logic softRstPulse
);

    // ------------------------------------------------------------
    // pin sampling and edge detection
    // ------------------------------------------------------------
    asrp_pins_t pins_q; // previous pin levels
    logic rise; // sample edge
    logic fall; // drive edge

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pins_q <= '{sclk: 1'b1, csN: 1'b1, din: 1'b0}; // idle high clock
        end else if (clkEn) begin
            pins_q <= '{sclk: sclk, csN: csN, din: din};
        end
    end

    assign rise = ~pins_q.sclk & sclk & ~csN;
    assign fall = pins_q.sclk & ~sclk & ~csN;

    // ------------------------------------------------------------
    // all-ones reset detector
    // ------------------------------------------------------------
    logic [ONES_W-1:0] ones_q; // consecutive high data bits
    logic softRst; // reset request this cycle

    assign softRst = rise && din && (ones_q == ONES_W'(RESET_ONES - 1));

    // counts across framing, cleared by a low bit or by the reset it fires; chip select high does not break it
    always_ff @(posedge clk_sys) begin
        if (rst || (clkEn && softRst)) begin
            ones_q <= '0;
        end else if (clkEn && rise) begin
            ones_q <= din ? ones_q + 1'b1 : '0;
        end
    end

    // ------------------------------------------------------------
    // framing state
    // ------------------------------------------------------------
    asrp_state_t state_q; // framing state
    logic [5:0] cnt_q; // bits in current phase
    logic [5:0] len_q; // data phase length
    logic [5:0] addr_q; // target_reg_index
    logic [31:0] sh_q; // shift register
    asrp_wr_t wr_q; // write strobe to registers
    logic [5:0] lookBits; // width of looked up register
    logic [31:0] lookData; // value of looked up register
    logic [5:0] lookAddr; // address under decode
    logic [7:0] cmdByte; // command byte as it completes

    assign cmdByte = {sh_q[6:0], din};
    // during the command byte the address is the byte being completed
    assign lookAddr = (state_q == ST_CMD) ? cmdByte[CMD_ADDR_MSB:0] : addr_q;

    // framing machine: command, then one data phase, then back
    always_ff @(posedge clk_sys) begin
        if (rst || (clkEn && (softRst || csN))) begin
            state_q <= ST_CMD;
            cnt_q <= '0;
            len_q <= 6'd8;
            addr_q <= '0;
        end else if (clkEn && rise) begin
            unique case (state_q)
                ST_CMD: begin
                    if (cnt_q == 6'd7) begin
                        cnt_q <= '0;
                        addr_q <= cmdByte[CMD_ADDR_MSB:0];
                        len_q <= lookBits;
                        // a set write-enable bit makes the byte a no-op
                        if (cmdByte[CMD_WEN_N_BIT]) begin
                            state_q <= ST_CMD;
                        end else if (cmdByte[CMD_READ_BIT]) begin
                            state_q <= ST_READ;
                        end else begin
                            state_q <= ST_WRITE;
                        end
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_WRITE, ST_READ: begin
                    if (cnt_q == len_q - 1'b1) begin
                        state_q <= ST_CMD;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // shift register: sample in on rise, reload read data at command end
    always_ff @(posedge clk_sys) begin
        if (rst || (clkEn && (softRst || csN))) begin
            sh_q <= '0;
        end else if (clkEn && rise) begin
            if (state_q == ST_CMD && cnt_q == 6'd7 && !cmdByte[CMD_WEN_N_BIT] && cmdByte[CMD_READ_BIT]) begin
                // left-align so the msb leaves first
                sh_q <= lookData << (6'd32 - lookBits);
            end else if (state_q == ST_READ) begin
                sh_q <= {sh_q[30:0], 1'b0};
            end else begin
                sh_q <= {sh_q[30:0], din};
            end
        end
    end

    // write strobe: one cycle when the last data bit lands
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_q <= '0;
        end else if (clkEn) begin
            wr_q.valid <= 1'b0;
            if (rise && state_q == ST_WRITE && cnt_q == len_q - 1'b1 && !csN && !softRst) begin
                // command and identification registers take no data
                wr_q.valid <= (addr_q != ADDR_COMMAND) && (addr_q != ADDR_IDENT);
                wr_q.addr <= addr_q;
                wr_q.data <= 24'({sh_q[22:0], din});
            end
        end
    end

    // ------------------------------------------------------------
    // output pin: driven on the falling edge during a read
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || (clkEn && csN)) begin
            dout <= 1'b1;
            doutOeN <= 1'b1;
        end else if (clkEn && fall) begin
            doutOeN <= (state_q != ST_READ);
            dout <= (state_q == ST_READ) ? sh_q[31] : 1'b1;
        end
    end

    // soft reset pulse, visible to the rest of the device
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            softRstPulse <= 1'b0;
        end else if (clkEn) begin
            softRstPulse <= softRst;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    asrp_regfile #(
        .IDENT_VALUE(IDENT_VALUE)
    ) u_regs (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .softRst(softRst),
        .wr(wr_q),
        .lookAddr(lookAddr),
        .lookBits(lookBits),
        .lookData(lookData),
        .ifMode()
    );

endmodule
`default_nettype wire

/* asrp_port_monitor.sv */
// concurrent checks on the serial register port pins
`timescale 1ns/1ns
`default_nettype none
module asrp_port_monitor
    import asrp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    // serial pins
    input wire logic sclk,
    input wire logic csN,
    input wire logic din,
    input wire logic dout,
    input wire logic doutOeN,
    // status
    input wire logic softRstPulse
);
    // ------
    // helper logic
    // ------
    logic sclkPrev_q; // last sampled serial clock, idle high
    logic [7:0] onesCnt_q; // run of rises with din high, saturating
    // counts taken rises with din high, a low bit restarts the run
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sclkPrev_q <= 1'b1;
            onesCnt_q <= 8'h00;
        end else if (clkEn) begin
            sclkPrev_q <= sclk;
            if (softRstPulse) begin
                // the device starts a fresh run after its own reset, so must the model
                onesCnt_q <= 8'h00;
            end else if (sclk && !sclkPrev_q && !csN) begin
                // saturate so a long run never wraps back below the threshold
                onesCnt_q <= !din ? 8'h00 : (onesCnt_q == 8'hff) ? onesCnt_q : onesCnt_q + 8'h01;
            end
        end
    end
    // ------
    // assertions
    // ------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    reset_release_a: assert property (disable iff (1'b0) rst |=> doutOeN && dout && !softRstPulse)
        else $error("output not released during reset");
    drive_edge_a: assert property ((!doutOeN && $past(!doutOeN) && $changed(dout)) |->
        !$past(sclk) && $past(sclk, 2)) else $error("data out moved away from a falling edge");
    oe_timing_a: assert property ($fell(doutOeN) |-> !$past(sclk) && $past(sclk, 2))
        else $error("read data started away from a falling edge");
    cs_release_a: assert property (($rose(csN) && clkEn) |=> doutOeN)
        else $error("chip select high did not release data out");
    oe_select_a: assert property (!doutOeN |-> !$past(csN))
        else $error("data out driven while deselected");
    pulse_single_a: assert property (softRstPulse |=> !softRstPulse)
        else $error("soft reset pulse longer than one cycle");
    pulse_cause_a: assert property (softRstPulse |-> $past(din) && $past(sclk) && !$past(sclk, 2))
        else $error("soft reset pulse without a high rise");
    ones_count_a: assert property (softRstPulse |-> onesCnt_q >= 8'd64)
        else $error("soft reset before 64 high rises");
    idle_high_a: assert property (doutOeN |-> dout)
        else $error("released data out not high");
    // main scenarios
    cover property (softRstPulse);
    cover property ($fell(doutOeN));
    cover property ($rose(csN) && !doutOeN);
endmodule
bind asrp_port asrp_port_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .sclk(sclk),
    .csN(csN), .din(din), .dout(dout), .doutOeN(doutOeN), .softRstPulse(softRstPulse));
`default_nettype wire

/* asrp_host_model.sv */
// host side model that frames commands and data on the serial pins
`timescale 1ns/1ns
`default_nettype none
module asrp_host_model (
    // clock
    input wire logic clk_sys,
    // serial pins toward the port
    output var logic sclk,
    output var logic csN,
    output var logic din,
    input wire logic dout
);
    // ------
    // bit engine
    // ------
    // drive on the fall, capture on the rise, msb first, three clocks per level
    task automatic shift(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk_sys);
            sclk <= 1'b0;
            din <= tx[i];
            repeat (3) @(posedge clk_sys);
            sclk <= 1'b1;
            rx = {rx[30:0], dout};
            repeat (2) @(posedge clk_sys);
        end
        // a held line would hide late sampling, so din flips once the frame ends
        @(posedge clk_sys);
        din <= ~din;
    endtask
    // ------
    // transactions
    // ------
    // command byte first, then the data phase of the register width
    task automatic access(input logic rd, input logic [5:0] addr, input int n,
        input logic [31:0] wdata, output logic [31:0] rdata);
        logic [31:0] unused;
        shift(8, {24'h0, 1'b0, rd, addr}, unused);
        shift(n, wdata, rdata);
    endtask
    // chip select high between frames, sclk stays idle high meanwhile
    task automatic frame_break();
        @(posedge clk_sys);
        csN <= 1'b1;
        repeat (3) @(posedge clk_sys);
        csN <= 1'b0;
    endtask
    // 64 high rises put the device back in step after lost framing
    task automatic resync();
        logic [31:0] unused;
        shift(32, 32'hffffffff, unused);
        shift(32, 32'hffffffff, unused);
    endtask
    // idle: clock high, chip select tied low for three-wire use
    initial begin
        sclk = 1'b1;
        csN = 1'b0;
        din = 1'b1;
    end
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the adc serial register port
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import asrp_pkg::*;
    localparam logic [15:0] ID_VAL = 16'h3c90; // arbitrary identity value
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    logic sclk, csN, din, dout, doutOeN, softRstPulse;
    int fail_count = 0;
    int tests_run = 0;
    int pulses = 0; // soft reset pulses seen
    logic [31:0] rd; // last read data
    logic [5:0] ra [8] = '{ADDR_ADC_MODE, ADDR_IF_MODE, ADDR_CHAN0, 6'h11, ADDR_SETUP0, ADDR_FILT0,
        ADDR_OFFSET0, ADDR_GAIN0};
    logic [31:0] rv [8] = '{32'(RST_ADC_MODE), 32'(RST_IF_MODE), 32'(RST_CHAN0), 32'(RST_CHANX),
        32'(RST_SETUP0), 32'(RST_FILT0), 32'(RST_OFFSET0), 32'(RST_GAIN0)};
    // ------
    // clock, design and host
    // ------
    always #20 clk_sys = ~clk_sys;
    asrp_port #(.IDENT_VALUE(ID_VAL)) u_dut (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .sclk(sclk),
        .csN(csN), .din(din), .dout(dout), .doutOeN(doutOeN), .softRstPulse(softRstPulse));
    asrp_host_model u_host (.clk_sys(clk_sys), .sclk(sclk), .csN(csN), .din(din), .dout(dout));
    always @(posedge clk_sys) begin
        if (softRstPulse === 1'b1) begin
            pulses++;
        end
    end
    // ------
    // checking and verdict
    // ------
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic read_id(input string what);
        u_host.access(1'b1, ADDR_IDENT, 16, 32'h0, rd);
        check(rd >> 4, 32'(ID_VAL[15:4]), what);
    endtask
    // a hang counts as a failure
    initial begin
        repeat (60000) @(posedge clk_sys);
        fail_count++;
        end_of_test();
    end
    // ------
    // scenarios
    // ------
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        read_id("ident after reset");
        for (int i = 0; i < 8; i++) begin
            u_host.access(1'b1, ra[i], (ra[i] >= 6'h30) ? 24 : 16, 32'h0, rd);
            check(rd, rv[i], "reset value");
        end
        // widths of 24, 16 and 8 bits back to back
        u_host.access(1'b0, ADDR_OFFSET0, 24, 32'h005ac3e1, rd);
        u_host.access(1'b0, ADDR_FILT0, 16, 32'h00000f1e, rd);
        u_host.access(1'b0, 6'h05, 8, 32'h000000ff, rd);
        u_host.access(1'b1, ADDR_OFFSET0, 24, 32'h0, rd);
        check(rd, 32'h005ac3e1, "offset write");
        u_host.access(1'b1, ADDR_FILT0, 16, 32'h0, rd);
        check(rd, 32'h00000f1e, "filter write");
        u_host.access(1'b1, 6'h05, 8, 32'h0, rd);
        check(rd, 32'h0, "unmapped read");
        // command register cannot be read, ident cannot be written
        u_host.access(1'b1, ADDR_COMMAND, 8, 32'h0, rd);
        check(rd, 32'h0, "command read");
        u_host.access(1'b0, ADDR_IDENT, 16, 32'h0000ffff, rd);
        read_id("ident after write");
        // write enable high: the byte is dropped, next byte is a command
        u_host.shift(8, 32'h000000c7, rd);
        read_id("ident after disabled command");
        // chip select aborts a read and a write in mid-phase
        u_host.shift(8, 32'h00000047, rd);
        u_host.shift(5, 32'h0, rd);
        u_host.frame_break();
        read_id("ident after aborted read");
        u_host.shift(8, 32'h00000030, rd);
        u_host.shift(8, 32'h000000ff, rd);
        u_host.frame_break();
        u_host.access(1'b1, ADDR_OFFSET0, 24, 32'h0, rd);
        check(rd, 32'h005ac3e1, "aborted write");
        // status append stretches data reads to 32 bits
        u_host.access(1'b0, ADDR_IF_MODE, 16, 32'h00000040, rd);
        u_host.access(1'b1, ADDR_DATA, 32, 32'h0, rd);
        check(rd, 32'h0, "data with status");
        read_id("ident after long read");
        // clock enable low between command and data phase must keep the framing
        u_host.shift(8, 32'h00000047, rd);
        @(posedge clk_sys);
        clkEn <= 1'b0;
        repeat (5) @(posedge clk_sys);
        clkEn <= 1'b1;
        u_host.shift(16, 32'h0, rd);
        check(rd >> 4, 32'(ID_VAL[15:4]), "ident across clock enable low");
        // 64 high rises restore the registers
        u_host.access(1'b0, ADDR_ADC_MODE, 16, 32'h00001234, rd);
        u_host.resync();
        check(32'(pulses), 32'h1, "soft reset pulses");
        u_host.access(1'b1, ADDR_IF_MODE, 16, 32'h0, rd);
        check(rd, 32'(RST_IF_MODE), "if mode after soft reset");
        u_host.access(1'b1, ADDR_ADC_MODE, 16, 32'h0, rd);
        check(rd, 32'(RST_ADC_MODE), "adc mode after soft reset");
        u_host.access(1'b1, ADDR_OFFSET0, 24, 32'h0, rd);
        check(rd, 32'(RST_OFFSET0), "offset after soft reset");
        end_of_test();
    end
endmodule
`default_nettype wire
